// file: logic/sdiob_bank.sv
/*
 * sdiob_bank: servo diagnosis parameter bank. Holds the jog command,
 * forced-output word, software inputs and adjustment command; resolves
 * digital inputs and outputs; answers parameter reads.
 * Assumes: one access per cycle on req; function codes, source
 * selection and unlock setting come from the parameter store on mclk;
 * terminal and key pins are asynchronous.
 */
`timescale 1ns/1ps
// Functional notes
// - writing 1..5000 other than 4998, 4999 to the jog word sets jog speed, no motion
// - writing 4998 to the jog word starts counter-clockwise jog
// - writing 4999 to the jog word starts clockwise jog
// - writing zero to the jog word stops any jog
// - forced word is 16 bits; bit n matches function code 0x30+n
// - output assigned a forced code drives the matching forced bit
// - each of nine inputs comes from terminal or software bit
// - reading input status returns resolved inputs, not software bits
// - writing input status updates software bits only
// - input status bits 0..8 map to inputs one to nine
// - input status behaves the same from keypad or link
// - key status is read-only, 16 bits, five front-panel keys
// - output status reads current outputs, 0..0x1F, same everywhere
// - adjustment accepts 1..6; 0 reserved, 1 speed input drift
// - values 2..6 start torque, V, W, all-four, thermistor jobs
// - adjustment honoured only unlocked with 20, servo off, unwired
module sdiob_bank
	import sdiob_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// parameter access, link or keypad
	input  wire sdiob_req_t        req,
	input  wire logic              forceSel,
	output sdiob_rsp_t             rsp,
	// digital inputs
	input  wire logic [DI_N-1:0]   diPin,
	input  wire logic [DI_N-1:0]   diSrcSoft,
	output logic      [DI_N-1:0]   diFinal,
	// digital outputs
	input  wire logic [DO_N-1:0][7:0] doFunc,
	input  wire logic [DO_N-1:0]   doNormal,
	output logic      [DO_N-1:0]   doOut,
	// keypad
	input  wire logic [KEY_N-1:0]  keyPin,
	// jog
	output sdiob_jog_t             jog,
	// drift adjustment
	input  wire logic [15:0]       protUnlock,
	input  wire logic              servoOn,
	input  wire logic              analogWired,
	input  wire logic              adjDone,
	output logic      [2:0]        adjKind,
	output logic                   adjStart
);

	// true when a function code selects a forced bit
	function automatic logic isForced(input logic [7:0] code);
		return (code >= FORCE_CODE_LO) && (code <= FORCE_CODE_HI);
	endfunction : isForced

	// true when a write hits a given word
	function automatic logic hitWr(input sdiob_req_t r,
		input logic [15:0] a);
		return r.wr && (r.addr == a);
	endfunction : hitWr

	logic [DI_N-1:0]  diSync;
	logic [KEY_N-1:0] keySync;
	logic [15:0]      jogCmd_r;
	logic [15:0]      forceWord_r;
	logic [8:0]       swIn_r;
	logic [15:0]      adjCmd_r;
	logic             adjAllowed;
	logic             adjWrOk;
	logic [DI_N-1:0]  diFinal_nxt;
	logic [15:0]      rdData_nxt;
	logic             rdErr_nxt;

	// terminal levels are asynchronous
	sdiob_sync #(.W(DI_N)) uDiSync (
		.mclk (mclk),
		.rstn (rstn),
		.din  (diPin),
		.dout (diSync)
	);

	// key levels are asynchronous
	sdiob_sync #(.W(KEY_N)) uKeySync (
		.mclk (mclk),
		.rstn (rstn),
		.din  (keyPin),
		.dout (keySync)
	);

	// jog command word and motion requests
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			jogCmd_r  <= JOG_RESET;
			jog.speed <= JOG_RESET;
			jog.ccw   <= 1'b0;
			jog.cw    <= 1'b0;
		end else if (hitWr(req, ADDR_JOG)) begin
			if (req.data == JOG_STOP) begin
				jogCmd_r <= req.data;
				jog.ccw  <= 1'b0;
				jog.cw   <= 1'b0;
			end else if (req.data == JOG_CCW) begin
				jogCmd_r <= req.data;
				jog.ccw  <= 1'b1;
				jog.cw   <= 1'b0;
			end else if (req.data == JOG_CW) begin
				jogCmd_r <= req.data;
				jog.ccw  <= 1'b0;
				jog.cw   <= 1'b1;
			end else if (req.data <= JOG_SPEED_MAX) begin
				jogCmd_r  <= req.data;
				jog.speed <= req.data;
			end
		end
	end

	// forced word or software inputs share one address
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			forceWord_r <= FORCE_RESET;
			swIn_r      <= SWIN_RESET;
		end else if (hitWr(req, ADDR_FORCE_IN)) begin
			if (forceSel)
				forceWord_r <= req.data;
			else
				swIn_r <= req.data[8:0];
		end
	end

	// per-input source selection
	always_comb begin
		for (int i = 0; i < DI_N; i++) begin
			diFinal_nxt[i] = diSrcSoft[i] ? swIn_r[i] : diSync[i];
		end
	end

	// resolved inputs, registered for the status read
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			diFinal <= '0;
		else
			diFinal <= diFinal_nxt;
	end

	// outputs follow forced bits when their code is in the window
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			doOut <= '0;
		end else begin
			for (int k = 0; k < DO_N; k++) begin
				if (isForced(doFunc[k]))
					doOut[k] <= forceWord_r[doFunc[k][3:0]];
				else
					doOut[k] <= doNormal[k];
			end
		end
	end

	// adjustment gate: unlocked, servo off, analog inputs unwired
	assign adjAllowed = (protUnlock == UNLOCK_CODE) && !servoOn
		&& !analogWired;
	assign adjWrOk = hitWr(req, ADDR_ADJUST) && adjAllowed
		&& (req.data <= ADJ_MAX) && (req.data != ADJ_RESET);

	// adjustment command and start pulse
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			adjCmd_r <= ADJ_RESET;
			adjKind  <= 3'h0;
			adjStart <= 1'b0;
		end else begin
			adjStart <= 1'b0;
			if (adjWrOk) begin
				adjCmd_r <= req.data;
				adjKind  <= req.data[2:0];
				adjStart <= 1'b1;
			end else if (adjDone) begin
				adjCmd_r <= ADJ_RESET;
			end
		end
	end

	// read mux; unknown address answers zero with error
	always_comb begin
		rdData_nxt = 16'h0000;
		rdErr_nxt  = 1'b0;
		unique case (req.addr)
			ADDR_JOG:      rdData_nxt = jogCmd_r;
			ADDR_FORCE_IN: rdData_nxt = forceSel ? forceWord_r
				: {7'h00, diFinal};
			ADDR_KEYS:     rdData_nxt = {11'h000, keySync};
			ADDR_OUTSTAT:  rdData_nxt = {11'h000, doOut};
			ADDR_ADJUST:   rdData_nxt = adjCmd_r;
			default:       rdErr_nxt  = 1'b1;
		endcase
	end

	// answer one cycle after a read; writes never answer
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.rd;
			rsp.err   <= req.rd & rdErr_nxt;
			rsp.data  <= req.rd ? rdData_nxt : 16'h0000;
		end
	end

	// checks run on mclk and stay quiet in reset
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// accepted adjustment write, then its one-cycle start pulse
	sequence sAdjGo;
		hitWr(req, ADDR_ADJUST) && adjAllowed && req.data >= 16'h0001
			&& req.data <= ADJ_MAX;
	endsequence

	sequence sAdjPulse;
		adjStart ##1 !adjStart;
	endsequence

	a_jog_speed_set: assert property (
		hitWr(req, ADDR_JOG) && req.data != JOG_STOP && req.data
		!= JOG_CCW && req.data != JOG_CW && req.data <= JOG_SPEED_MAX
		|=> jog.speed == $past(req.data) && jog.ccw == $past(jog.ccw)
		&& jog.cw == $past(jog.cw))
		else $error("jog speed write wrong");
	a_jog_ccw_run: assert property (
		hitWr(req, ADDR_JOG) && req.data == JOG_CCW
		|=> jog.ccw && !jog.cw)
		else $error("ccw jog not started");
	a_jog_cw_run: assert property (
		hitWr(req, ADDR_JOG) && req.data == JOG_CW
		|=> jog.cw && !jog.ccw)
		else $error("cw jog not started");
	a_jog_stop: assert property (
		hitWr(req, ADDR_JOG) && req.data == JOG_STOP
		|=> !jog.cw && !jog.ccw)
		else $error("jog not stopped");
	a_forced_out: assert property (
		isForced(doFunc[0]) |=> doOut[0] == $past(forceWord_r[doFunc[0][3:0]]))
		else $error("first output ignores forced bit");
	a_status_read: assert property (
		req.rd && req.addr == ADDR_FORCE_IN && !forceSel
		|=> rsp.valid && rsp.data == {7'h00, $past(diFinal)})
		else $error("input status read wrong");
	a_soft_write: assert property (
		hitWr(req, ADDR_FORCE_IN) && !forceSel
		|=> swIn_r == $past(req.data[8:0]) && forceWord_r
		== $past(forceWord_r))
		else $error("software input write wrong");
	a_key_read: assert property (
		req.rd && req.addr == ADDR_KEYS
		|=> rsp.data[15:5] == 11'h000 && rsp.data[4:0] == $past(keySync))
		else $error("key status read wrong");
	a_out_read: assert property (
		req.rd && req.addr == ADDR_OUTSTAT
		|=> rsp.data == {11'h000, $past(doOut)})
		else $error("output status read wrong");
	// a second accepted write next cycle stretches the pulse legally
	a_adj_start: assert property (
		sAdjGo ##1 !hitWr(req, ADDR_ADJUST) |-> sAdjPulse)
		else $error("adjustment start pulse wrong");
	a_adj_locked: assert property (
		hitWr(req, ADDR_ADJUST) && !adjAllowed
		|=> !adjStart && adjKind == $past(adjKind))
		else $error("locked adjustment accepted");

	a_force_write: assert property (
		hitWr(req, ADDR_FORCE_IN) && forceSel
		|=> forceWord_r == $past(req.data) && swIn_r == $past(swIn_r))
		else $error("forced word write wrong");
	a_input_pick: assert property (
		1'b1 |=> diFinal == (($past(diSrcSoft) & $past(swIn_r))
		| (~$past(diSrcSoft) & $past(diSync))))
		else $error("input source selection wrong");
	a_adj_kind: assert property (
		sAdjGo |=> adjKind == $past(req.data[2:0])
		&& adjCmd_r == $past(req.data))
		else $error("adjustment kind wrong");
	a_adj_range: assert property (
		hitWr(req, ADDR_ADJUST)
		&& (req.data == ADJ_RESET || req.data > ADJ_MAX)
		|=> !adjStart && adjKind == $past(adjKind))
		else $error("out of range adjustment accepted");
	a_jog_ignore: assert property (
		hitWr(req, ADDR_JOG) && req.data > JOG_SPEED_MAX
		|=> jog == $past(jog) && jogCmd_r == $past(jogCmd_r))
		else $error("jog write above limit accepted");
	a_out_normal: assert property (
		!isForced(doFunc[2]) |=> doOut[2] == $past(doNormal[2]))
		else $error("unforced output ignores normal state");
	a_forced_hi: assert property (
		isForced(doFunc[1]) |=> doOut[1] == $past(forceWord_r[doFunc[1][3:0]]))
		else $error("second output ignores forced bit");

endmodule : sdiob_bank

// file: logic/sdiob_pkg.sv
/*
 * sdiob_pkg: constants and carrier types of the servo diagnosis
 * parameter bank (jog, forced outputs, input status, keypad, outputs,
 * drift adjustment).
 * Assumes: 16-bit parameter words reached by word address over the
 * drive's communication link or the keypad, both on mclk.
 */
package sdiob_pkg;

	// word addresses of the parameter bank
	localparam logic [15:0] ADDR_JOG      = 16'h040a;
	localparam logic [15:0] ADDR_FORCE_IN = 16'h040c; // forced / input
	localparam logic [15:0] ADDR_KEYS     = 16'h0410;
	localparam logic [15:0] ADDR_OUTSTAT  = 16'h0412;
	localparam logic [15:0] ADDR_ADJUST   = 16'h0414;

	// jog command encodings
	localparam logic [15:0] JOG_STOP      = 16'h0000;
	localparam logic [15:0] JOG_SPEED_MAX = 16'h1388; // 5000 r/min
	localparam logic [15:0] JOG_CCW       = 16'h1386; // 4998
	localparam logic [15:0] JOG_CW        = 16'h1387; // 4999
	localparam logic [15:0] JOG_RESET     = 16'h0014; // 20 r/min

	// forced-output function code window
	localparam logic [7:0]  FORCE_CODE_LO = 8'h30;
	localparam logic [7:0]  FORCE_CODE_HI = 8'h3f;

	// adjustment command
	localparam logic [15:0] ADJ_RESET     = 16'h0000;
	localparam logic [15:0] ADJ_MAX       = 16'h0006;
	localparam logic [15:0] UNLOCK_CODE   = 16'h0014; // 20

	// widths and reset values
	localparam int          DI_N          = 9;
	localparam int          DO_N          = 5;
	localparam int          KEY_N         = 5;
	localparam logic [8:0]  SWIN_RESET    = 9'h000;
	localparam logic [15:0] FORCE_RESET   = 16'h0000;

	// one parameter access from the link or keypad
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] data;
	} sdiob_req_t;

	// one parameter answer
	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] data;
	} sdiob_rsp_t;

	// jog state seen by the motion logic
	typedef struct packed {
		logic        ccw;
		logic        cw;
		logic [15:0] speed;
	} sdiob_jog_t;

endpackage : sdiob_pkg

// file: logic/sdiob_sync.sv
/*
 * sdiob_sync: two-flop synchroniser for a bundle of pin levels.
 * Assumes: inputs are asynchronous levels; output is read in mclk.
 */
`timescale 1ns/1ps
module sdiob_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_r;

	// first flop feeds only the second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule : sdiob_sync

// file: testbench/sdiob_bank_test.sv
/*
 * sdiob_bank_test: self-checking bench of the parameter bank.
 * Assumes: host model drives req; every other input is driven here.
 */
`timescale 1ns/1ps
module sdiob_bank_test import sdiob_pkg::*;;
	logic                 mclk, rstn, forceSel, servoOn;
	logic                 analogWired, adjDone, adjStart;
	logic [DI_N-1:0]      diPin, diSrcSoft, diFinal;
	logic [DO_N-1:0][7:0] doFunc;
	logic [DO_N-1:0]      doNormal, doOut;
	logic [KEY_N-1:0]     keyPin;
	logic [15:0]          protUnlock;
	logic [2:0]           adjKind, lastKind;
	sdiob_req_t           req;
	sdiob_rsp_t           rsp, r;
	sdiob_jog_t           jog;
	int                   nErrors = 0, compares = 0, nStart = 0;

	sdiob_host i_host (.mclk(mclk), .req(req), .rsp(rsp));
	sdiob_bank i_dut (
		.mclk(mclk), .rstn(rstn), .req(req), .forceSel(forceSel),
		.rsp(rsp), .diPin(diPin), .diSrcSoft(diSrcSoft),
		.diFinal(diFinal), .doFunc(doFunc), .doNormal(doNormal),
		.doOut(doOut), .keyPin(keyPin), .jog(jog),
		.protUnlock(protUnlock), .servoOn(servoOn),
		.analogWired(analogWired), .adjDone(adjDone),
		.adjKind(adjKind), .adjStart(adjStart)
	);

	// clock, 8 ns period
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// counts adjustment start pulses
	always @(posedge mclk) begin
		if (adjStart === 1'b1) begin
			nStart <= nStart + 1;
			lastKind <= adjKind;
		end
	end

	task automatic chk(input logic [17:0] got, exp);
		compares++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [15:0] a, exp);
		i_host.rd(a, r);
		chk(r, {2'b10, exp});
	endtask : rdchk

	task automatic jw(input logic [15:0] d, input logic [1:0] dir);
		i_host.wr(ADDR_JOG, d);
		#1 chk({jog.ccw, jog.cw}, dir);
	endtask : jw

	// refused adjustment: no new start pulse
	task automatic adjNo(input logic [15:0] d);
		i_host.wr(ADDR_ADJUST, d);
		repeat (2) @(posedge mclk);
		#1 chk(nStart[15:0], 16'h0006);
	endtask : adjNo

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, nErrors);
		if (nErrors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// watchdog
	initial begin
		#50000;
		nErrors++;
		report_and_stop;
	end

	initial begin
		rstn = 1'b0;
		forceSel = 1'b1;
		servoOn = 1'b0;
		analogWired = 1'b0;
		adjDone = 1'b0;
		diPin = 9'h1a5;
		diSrcSoft = 9'h0f0;
		doFunc = {8'h00, 8'h00, 8'h00, 8'h3f, 8'h30};
		doNormal = 5'h1c;
		keyPin = 5'h15;
		protUnlock = UNLOCK_CODE;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		rdchk(ADDR_JOG, JOG_RESET);
		rdchk(ADDR_ADJUST, ADJ_RESET);
		// jog commands and refused speed
		jw(16'h0064, 2'b00);
		chk(jog.speed, 16'h0064);
		jw(JOG_CCW, 2'b10);
		jw(JOG_STOP, 2'b00);
		jw(JOG_CW, 2'b01);
		jw(16'h1389, 2'b01);
		rdchk(ADDR_JOG, JOG_CW);
		jw(JOG_STOP, 2'b00);
		jw(JOG_SPEED_MAX, 2'b00);
		chk(jog.speed, JOG_SPEED_MAX);
		$display("jog test done");
		// forced outputs, bits 0 and 15
		i_host.wr(ADDR_FORCE_IN, 16'h8000);
		@(posedge mclk);
		#1 chk(doOut, 5'h1e);
		rdchk(ADDR_OUTSTAT, 16'h001e);
		i_host.wr(ADDR_FORCE_IN, 16'h0001);
		@(posedge mclk);
		#1 chk(doOut, 5'h1d);
		$display("forced output test done");
		// software inputs mixed with terminals
		@(posedge mclk) forceSel <= 1'b0;
		i_host.wr(ADDR_FORCE_IN, 16'h0011);
		@(posedge mclk);
		#1 chk(diFinal, 9'h115);
		rdchk(ADDR_FORCE_IN, 16'h0115);
		@(posedge mclk) diSrcSoft <= 9'h1ff;
		repeat (2) @(posedge mclk);
		#1 chk(diFinal, 9'h011);
		$display("input status test done");
		// keys read-only, unmapped read
		rdchk(ADDR_KEYS, 16'h0015);
		i_host.wr(ADDR_KEYS, 16'hffff);
		rdchk(ADDR_KEYS, 16'h0015);
		i_host.rd(16'h0400, r);
		chk(r, {2'b11, 16'h0000});
		$display("key status test done");
		// every adjustment kind
		for (int k = 1; k <= 6; k++) begin
			i_host.wr(ADDR_ADJUST, 16'(k));
			repeat (2) @(posedge mclk);
			#1 chk({nStart[12:0], lastKind}, {13'(k), 3'(k)});
			rdchk(ADDR_ADJUST, 16'(k));
			@(posedge mclk) adjDone <= 1'b1;
			@(posedge mclk) adjDone <= 1'b0;
		end
		rdchk(ADDR_ADJUST, ADJ_RESET);
		adjNo(16'h0000);
		adjNo(16'h0007);
		@(posedge mclk) servoOn <= 1'b1;
		adjNo(16'h0001);
		@(posedge mclk) servoOn <= 1'b0;
		analogWired <= 1'b1;
		adjNo(16'h0001);
		@(posedge mclk) analogWired <= 1'b0;
		protUnlock <= 16'h0000;
		adjNo(16'h0001);
		$display("adjustment test done");
		report_and_stop;
	end
endmodule : sdiob_bank_test

// file: testbench/sdiob_host.sv
/*
 * sdiob_host: link host that issues parameter reads and writes.
 * Assumes: req is taken at mclk rise; read answer within two edges.
 */
`timescale 1ns/1ps
module sdiob_host
	import sdiob_pkg::*;
(
	// clock
	input  wire logic       mclk,
	// parameter access
	output sdiob_req_t      req,
	input  wire sdiob_rsp_t rsp
);
	initial req = '0;

	// one strobe cycle, then the idle bus shows inverted values
	task automatic put(input logic w, input logic [15:0] a, d);
		@(posedge mclk);
		req <= '{w, ~w, a, d};
		@(posedge mclk);
		req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : put

	// one write; flash wear limit is set outside this bank
	task automatic wr(input logic [15:0] a, d);
		put(1'b1, a, d);
	endtask : wr

	// one read, answer awaited for two edges at most
	task automatic rd(input logic [15:0] a, output sdiob_rsp_t r);
		put(1'b0, a, 16'h0000);
		r = '0;
		for (int i = 0; i < 2 && r.valid !== 1'b1; i++) begin
			#1 r = rsp;
			if (r.valid !== 1'b1) @(posedge mclk);
		end
	endtask : rd
endmodule : sdiob_host
